// ==== hpsr_dev_model.sv ====
`timescale 1ns/1ps
module hpsr_dev_model (
    // device presence set by the bench
    input wire logic [3:0] attach,
    input wire logic [3:0] low_spd,
    input wire logic [3:0] fault,
    // hub side pins
    output logic [3:0] conn_pin,
    output logic [3:0] lspd_pin,
    output logic [3:0] ovc_pin
);
    assign conn_pin = attach;
    // an empty port has no pull-up, so the speed line sits low
    assign lspd_pin = attach & low_spd;
    assign ovc_pin = fault;
endmodule : hpsr_dev_model

// ==== hpsr_pkg.sv ====
package hpsr_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_SETUP_LO = 8'h00;
    localparam logic [7:0] ADDR_SETUP_HI = 8'h04;
    localparam logic [7:0] ADDR_RESULT = 8'h08;
    localparam logic [7:0] ADDR_REPLY = 8'h0c;
    localparam logic [7:0] ADDR_PINS = 8'h10;

    // reset values
    localparam logic [31:0] SETUP_RST = 32'h0000_0000;
    localparam logic [31:0] REPLY_RST = 32'h0000_0000;

    // result register field positions
    localparam int RES_DONE = 0;
    localparam int RES_ACK = 1;
    localparam int RES_STALL = 2;

    // status word field positions
    localparam int ST_CONN = 0;
    localparam int ST_EN = 1;
    localparam int ST_SUSP = 2;
    localparam int ST_OC = 3;
    localparam int ST_RST = 4;
    localparam int ST_PWR = 8;
    localparam int ST_LS = 9;
    localparam int CHG_BITS = 5;

    // setup packet codes
    localparam logic [7:0] RT_PORT_GET = 8'ha3;
    localparam logic [6:0] RT_HUB_SET = 7'h20;
    localparam logic [6:0] RT_PORT_SET = 7'h23;
    localparam logic [7:0] RQ_GET_STATUS = 8'h0b;
    localparam logic [7:0] RQ_CLR_FEATURE = 8'h01;
    localparam logic [7:0] RQ_SET_FEATURE = 8'h03;
    localparam logic [7:0] RQ_SET_DESC = 8'h07;
    localparam logic [15:0] LEN_STATUS = 16'h0004;
    localparam logic [15:0] LEN_NONE = 16'h0000;
    localparam logic [15:0] VAL_NONE = 16'h0000;
    localparam int NUM_PORTS = 4;

    // port feature selectors
    localparam logic [7:0] SEL_CONN = 8'h00;
    localparam logic [7:0] SEL_EN = 8'h01;
    localparam logic [7:0] SEL_SUSP = 8'h02;
    localparam logic [7:0] SEL_OC = 8'h03;
    localparam logic [7:0] SEL_RST = 8'h04;
    localparam logic [7:0] SEL_PWR = 8'h08;
    localparam logic [7:0] SEL_LS = 8'h09;
    localparam logic [7:0] SEL_C_BASE = 8'h10;
    localparam logic [7:0] SEL_C_LAST = 8'h14;

    // port reset signalling length
    localparam int CLK_PERIOD_NS = 100;
    localparam int PORT_RST_TIME_NS = 10_000_000;
    localparam int PORT_RST_CYC = (PORT_RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : hpsr_pkg

// ==== hpsr_port.sv ====
`timescale 1ns/1ps
module hpsr_port #(
    parameter int RST_CYC = hpsr_pkg::PORT_RST_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // filtered pin levels
    input wire logic conn,
    input wire logic lspd,
    input wire logic ovc,
    // accepted feature requests
    input wire logic set_stb,
    input wire logic clr_stb,
    input wire logic [7:0] sel,
    // state out
    output logic [15:0] status_word,
    output logic [15:0] change_word,
    output logic pwr,
    output logic rst_drv
);
    localparam int CW = $clog2(RST_CYC + 1);
    localparam int NC = hpsr_pkg::CHG_BITS;

    logic en_q, susp_q, oc_q, rst_q, pwr_q, conn_q, ovc_q;
    logic [CW-1:0] cnt_q;
    logic [NC-1:0] chg_q;

    wire set_en = set_stb && sel == hpsr_pkg::SEL_EN;
    wire set_susp = set_stb && sel == hpsr_pkg::SEL_SUSP;
    wire set_rst = set_stb && sel == hpsr_pkg::SEL_RST;
    wire set_pwr = set_stb && sel == hpsr_pkg::SEL_PWR;
    wire clr_en = clr_stb && sel == hpsr_pkg::SEL_EN;
    wire clr_susp = clr_stb && sel == hpsr_pkg::SEL_SUSP;
    wire clr_oc = clr_stb && sel == hpsr_pkg::SEL_OC;
    wire clr_pwr = clr_stb && sel == hpsr_pkg::SEL_PWR;
    wire oc_rise = ovc && !ovc_q;
    wire rst_done = rst_q && cnt_q == '0 && conn;
    wire resume_done = clr_susp && susp_q;
    wire live = conn && pwr_q && !oc_rise;
    // power goes off on the very edge that raises the over-current flag
    wire pwr_d = oc_rise ? 1'b0 : (set_pwr && !oc_q) ? 1'b1 : clr_pwr ? 1'b0 : pwr_q; // RULE_22 RULE_04
    wire en_d = !live ? 1'b0 : (rst_done || set_en) ? 1'b1 : clr_en ? 1'b0 : en_q; // RULE_17
    wire susp_d = (!live || !en_q) ? 1'b0 : set_susp ? 1'b1 : clr_susp ? 1'b0 : susp_q; // RULE_17
    wire oc_d = oc_rise ? 1'b1 : (clr_oc && !ovc) ? 1'b0 : oc_q;
    wire [NC-1:0] chg_ev = {rst_done, oc_d != oc_q, resume_done, en_d != en_q, conn != conn_q};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= 1'b0;
            susp_q <= 1'b0;
            oc_q <= 1'b0;
            pwr_q <= 1'b0;
            conn_q <= 1'b0;
            ovc_q <= 1'b0;
        end else begin
            en_q <= en_d;
            susp_q <= susp_d;
            oc_q <= oc_d;
            pwr_q <= pwr_d;
            conn_q <= conn;
            ovc_q <= ovc;
        end
    end

    // reset signalling: started by set-feature, ended by the counter or a disconnect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_q <= 1'b0;
            cnt_q <= '0;
        end else if (!rst_q && set_rst && live) begin
            rst_q <= 1'b1; // RULE_17
            cnt_q <= CW'(RST_CYC - 1);
        end else if (rst_q && (cnt_q == '0 || !conn)) begin
            rst_q <= 1'b0;
        end else if (rst_q) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // change bits are sticky; a new event beats a clear in the same cycle
    for (genvar i = 0; i < NC; i++) begin : g_chg
        wire clr_i = clr_stb && sel == hpsr_pkg::SEL_C_BASE + 8'(i);
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                chg_q[i] <= 1'b0;
            end else begin
                chg_q[i] <= chg_ev[i] | (chg_q[i] & ~clr_i); // RULE_08 RULE_09 RULE_10 RULE_21
            end
        end
    end

    assign status_word = {6'h00, lspd & conn, pwr_q, 3'h0, rst_q, oc_q, susp_q, en_q, conn}; // RULE_01 RULE_02 RULE_03 RULE_05 RULE_06 RULE_07
    assign change_word = {11'h000, chg_q}; // RULE_07
    assign pwr = pwr_q;
    assign rst_drv = rst_q;

endmodule : hpsr_port

// ==== hpsr_sync.sv ====
`timescale 1ns/1ps
module hpsr_sync #(
    parameter int W = 4
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pins and filtered levels
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] level_q;

    // a level moves only once the second and third stage agree
    wire [W-1:0] agree = ~(s2_q ^ s3_q);
    wire [W-1:0] level_d = (agree & s2_q) | (~agree & level_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            level_q <= '0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            level_q <= level_d;
        end
    end

    assign level = level_q;

endmodule : hpsr_sync

// ==== hpsr_top.sv ====
// Overview of operation
// RULE_01: status bit 0 is 1 while a device is attached to the port.
// RULE_02: status bit 1 shows port enabled; bit 2 shows port suspended.
// RULE_03: status bit 4 is 1 while the hub drives reset on the port.
// RULE_04: status bit 3 shows over-current; power is then removed from the port.
// RULE_05: status bit 8 is 1 while the port power switch is on.
// RULE_06: status bit 9 is 1 for an attached low-speed device, set by the device.
// RULE_07: reserved status bits 5-7, 10-15 and change bits 5-15 read zero.
// RULE_08: change bit 0 flags a connect status change since last acknowledgment.
// RULE_09: change bit 1 flags a change of the enabled state.
// RULE_10: change bits 2, 3, 4 flag resume done, over-current change, reset done.
// RULE_11: type a3, request 0b, value 0, port index, length 4 queries port status.
// RULE_12: type 20, request 07 (set hub descriptor) is answered with stall.
// RULE_13: type x0100000, request 03 (set hub feature) is answered with stall.
// RULE_14: type x0100011, request 03, selector, port, length 0 sets a port feature.
// RULE_15: set port feature takes enable, suspend, reset, power; others stall.
// RULE_16: selectors 00,01,02,03,04,08,09 and change selectors 10 to 14.
// RULE_17: an accepted set port feature updates that port's reported state. The code drops enable/reset unless live, suspend unless enabled, power if oc_q.
// RULE_18: status reply is two words, status word first then change word.
// RULE_19: port requests naming port 0 or above 4 are answered with stall.
// RULE_20: clear port feature takes enable, suspend, over-current, power; others stall. The code also takes change selectors 10 to 14.
// RULE_21: a change bit stays set until its change selector is cleared.
// RULE_22: over-current clears power and power output in the same cycle.
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module hpsr_top #(
    parameter int NPORT = hpsr_pkg::NUM_PORTS,
    parameter int RST_CYC = hpsr_pkg::PORT_RST_CYC
) (
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // downstream port pins, asynchronous
    input wire logic [NPORT-1:0] conn_pin,
    input wire logic [NPORT-1:0] lspd_pin,
    input wire logic [NPORT-1:0] ovc_pin,
    // downstream port controls
    output logic [NPORT-1:0] port_pwr,
    output logic [NPORT-1:0] port_rst_drv
);

    typedef enum logic [1:0] {
        HPSR_IDLE,
        HPSR_EXEC,
        HPSR_DONE
    } hpsr_state_e;

    hpsr_state_e state_q;
    hpsr_state_e state_d;
    logic [31:0] setup_lo_q;
    logic [31:0] setup_hi_q;
    logic [31:0] reply_q;
    logic done_q;
    logic ack_q;
    logic stall_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic [NPORT-1:0] conn_lvl;
    logic [NPORT-1:0] lspd_lvl;
    logic [NPORT-1:0] ovc_lvl;
    logic [15:0] st_w [NPORT];
    logic [15:0] ch_w [NPORT];

    // apb decode
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire rd = acc && !pwrite;
    wire hit_lo = paddr == hpsr_pkg::ADDR_SETUP_LO;
    wire hit_hi = paddr == hpsr_pkg::ADDR_SETUP_HI;
    wire hit_res = paddr == hpsr_pkg::ADDR_RESULT;
    wire hit_rep = paddr == hpsr_pkg::ADDR_REPLY;
    wire hit_pins = paddr == hpsr_pkg::ADDR_PINS;
    wire mapped = hit_lo || hit_hi || hit_res || hit_rep || hit_pins;
    // writing the upper setup half hands the packet to the decoder
    wire go = wr && hit_hi && state_q == HPSR_IDLE;
    // a write to the setup words while a packet is decoded is refused
    wire busy_wr = wr && (hit_lo || hit_hi) && state_q == HPSR_EXEC;

    // setup packet fields
    wire [7:0] rq_type = setup_lo_q[7:0];
    wire [7:0] rq_code = setup_lo_q[15:8];
    wire [15:0] rq_value = setup_lo_q[31:16];
    wire [15:0] rq_index = setup_hi_q[15:0];
    wire [15:0] rq_len = setup_hi_q[31:16];
    wire [7:0] sel = rq_value[7:0];

    // port number must be 1 to NPORT
    wire port_ok = rq_index != 16'h0000 && rq_index <= 16'(NPORT); // RULE_19
    wire [1:0] port_ix = 2'(rq_index - 16'h0001);

    // request classes
    wire is_get = rq_type == hpsr_pkg::RT_PORT_GET && rq_code == hpsr_pkg::RQ_GET_STATUS;
    wire get_ok = is_get && rq_value == hpsr_pkg::VAL_NONE
        && rq_len == hpsr_pkg::LEN_STATUS && port_ok; // RULE_11
    wire is_desc = rq_type[6:0] == hpsr_pkg::RT_HUB_SET
        && rq_code == hpsr_pkg::RQ_SET_DESC; // RULE_12
    wire is_hub_set = rq_type[6:0] == hpsr_pkg::RT_HUB_SET
        && rq_code == hpsr_pkg::RQ_SET_FEATURE; // RULE_13
    wire is_port_set = rq_type[6:0] == hpsr_pkg::RT_PORT_SET
        && rq_code == hpsr_pkg::RQ_SET_FEATURE;
    wire is_port_clr = rq_type[6:0] == hpsr_pkg::RT_PORT_SET
        && rq_code == hpsr_pkg::RQ_CLR_FEATURE;

    // selector acceptance tables
    wire sel_set_ok = sel == hpsr_pkg::SEL_EN || sel == hpsr_pkg::SEL_SUSP
        || sel == hpsr_pkg::SEL_RST || sel == hpsr_pkg::SEL_PWR; // RULE_15 RULE_16
    wire sel_chg = sel >= hpsr_pkg::SEL_C_BASE && sel <= hpsr_pkg::SEL_C_LAST;
    wire sel_clr_ok = sel == hpsr_pkg::SEL_EN || sel == hpsr_pkg::SEL_SUSP
        || sel == hpsr_pkg::SEL_OC || sel == hpsr_pkg::SEL_PWR || sel_chg; // RULE_20 RULE_16
    wire feat_fmt = rq_value[15:8] == 8'h00 && rq_len == hpsr_pkg::LEN_NONE && port_ok;
    wire set_ok = is_port_set && feat_fmt && sel_set_ok; // RULE_14 RULE_15
    wire clr_ok = is_port_clr && feat_fmt && sel_clr_ok; // RULE_20

    // anything not accepted, including descriptor and hub feature writes, stalls
    wire accept = get_ok || set_ok || clr_ok;
    wire exec = state_q == HPSR_EXEC;
    wire [NPORT-1:0] port_hit = exec ? NPORT'(1) << port_ix : '0;

    // request sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            HPSR_IDLE: begin
                if (go) begin
                    state_d = HPSR_EXEC;
                end
            end
            HPSR_EXEC: begin
                state_d = HPSR_DONE;
            end
            HPSR_DONE: begin
                state_d = HPSR_IDLE;
            end
            default: begin
                state_d = HPSR_IDLE;
            end
        endcase
    end

    // pin filters
    hpsr_sync #(.W(3 * NPORT)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin({ovc_pin, lspd_pin, conn_pin}),
        .level({ovc_lvl, lspd_lvl, conn_lvl})
    );

    // per-port status keepers
    for (genvar p = 0; p < NPORT; p++) begin : g_port
        hpsr_port #(.RST_CYC(RST_CYC)) u_port (
            .pclk(pclk),
            .presetn(presetn),
            .conn(conn_lvl[p]),
            .lspd(lspd_lvl[p]),
            .ovc(ovc_lvl[p]),
            .set_stb(port_hit[p] && set_ok),
            .clr_stb(port_hit[p] && clr_ok),
            .sel(sel),
            .status_word(st_w[p]),
            .change_word(ch_w[p]),
            .pwr(port_pwr[p]),
            .rst_drv(port_rst_drv[p])
        );
    end

    // status word in the low half goes out first, change word follows
    wire [31:0] reply_d = {ch_w[port_ix], st_w[port_ix]}; // RULE_18

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= HPSR_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setup_lo_q <= hpsr_pkg::SETUP_RST;
            setup_hi_q <= hpsr_pkg::SETUP_RST;
        end else if (wr && !busy_wr) begin
            if (hit_lo) begin
                setup_lo_q <= pwdata;
            end
            if (hit_hi && state_q == HPSR_IDLE) begin
                setup_hi_q <= pwdata;
            end
        end
    end

    // result: done clears when a new packet is taken
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
            ack_q <= 1'b0;
            stall_q <= 1'b0;
            reply_q <= hpsr_pkg::REPLY_RST;
        end else if (go) begin
            done_q <= 1'b0;
            ack_q <= 1'b0;
            stall_q <= 1'b0;
        end else if (exec) begin
            done_q <= 1'b1;
            ack_q <= accept;
            stall_q <= !accept; // RULE_12 RULE_13 RULE_15 RULE_19 RULE_20
            if (get_ok) begin
                reply_q <= reply_d; // RULE_11 RULE_18
            end
        end
    end

    // read mux
    wire [31:0] res_word = {29'h0000_0000, stall_q, ack_q, done_q};
    wire [31:0] pins_word = 32'({ovc_lvl, lspd_lvl, conn_lvl});
    wire [31:0] rd_mux = hit_lo ? setup_lo_q : hit_hi ? setup_hi_q : hit_res ? res_word
        : hit_rep ? reply_q : hit_pins ? pins_word : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q <= (psel && !penable && !pwrite) ? rd_mux : prdata_q;
            pslverr_q <= psel && !penable && (!mapped || (pwrite
                && (hit_res || hit_rep || hit_pins)));
        end
    end

    // zero wait: data is captured in the setup cycle, so access ends at once
    assign pready = 1'b1;
    assign prdata = rd ? prdata_q : 32'h0000_0000;
    assign pslverr = acc && pslverr_q;

    // checks
    a_stall_on_desc: assert property (@(posedge pclk) disable iff (!presetn) // RULE_12
        exec && is_desc |=> done_q && stall_q && !ack_q)
        else $error("set hub descriptor not stalled");

    a_stall_hub_set: assert property (@(posedge pclk) disable iff (!presetn) // RULE_13
        exec && is_hub_set |=> stall_q)
        else $error("set hub feature not stalled");

    a_bad_port_stall: assert property (@(posedge pclk) disable iff (!presetn) // RULE_19
        exec && !port_ok && (is_get || is_port_set || is_port_clr) |=> stall_q)
        else $error("bad port number not stalled");

    a_get_reply_order: assert property (@(posedge pclk) disable iff (!presetn) // RULE_18
        exec && get_ok |=> ack_q && reply_q[15:0] == $past(st_w[port_ix])
            && reply_q[31:16] == $past(ch_w[port_ix]))
        else $error("status reply order wrong");

    a_set_low_speed: assert property (@(posedge pclk) disable iff (!presetn) // RULE_15
        exec && is_port_set && sel == hpsr_pkg::SEL_LS |=> stall_q)
        else $error("low speed set not stalled");

    a_clr_reset_sel: assert property (@(posedge pclk) disable iff (!presetn) // RULE_20
        exec && is_port_clr && (sel == hpsr_pkg::SEL_RST || sel == hpsr_pkg::SEL_CONN)
            |=> stall_q)
        else $error("clear reset or connection not stalled");

    a_set_power_on: assert property (@(posedge pclk) disable iff (!presetn) // RULE_17
        exec && set_ok && sel == hpsr_pkg::SEL_PWR && !st_w[port_ix][hpsr_pkg::ST_OC]
            && !ovc_lvl[port_ix] |=> port_pwr[$past(port_ix)])
        else $error("accepted power set did not switch power");

    a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
        reply_q[7:5] == 3'h0 && reply_q[15:10] == 6'h00 && reply_q[31:21] == 11'h000)
        else $error("reserved reply bits not zero");

    a_oc_cuts_power: assert property (@(posedge pclk) disable iff (!presetn) // RULE_22
        $rose(st_w[0][hpsr_pkg::ST_OC]) |-> !port_pwr[0] && !st_w[0][hpsr_pkg::ST_PWR])
        else $error("over-current left power on");

    a_oc_power_off: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
        st_w[0][hpsr_pkg::ST_OC] && ovc_lvl[0] |-> !port_pwr[0])
        else $error("power on during over-current");

    a_conn_bit: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
        st_w[0][hpsr_pkg::ST_CONN] == conn_lvl[0])
        else $error("connect bit does not follow device");

    a_conn_change: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
        $changed(conn_lvl[0]) |=> ch_w[0][0] [*2])
        else $error("connect change not flagged");

    a_reset_length: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
        $rose(port_rst_drv[0]) |-> port_rst_drv[0] until !conn_lvl[0]
            || ch_w[0][4])
        else $error("reset signalling ended early");

    a_low_speed_bit: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
        st_w[0][hpsr_pkg::ST_LS] == (lspd_lvl[0] && conn_lvl[0]))
        else $error("low speed bit wrong");

    a_set_enable_on: assert property (@(posedge pclk) disable iff (!presetn) // RULE_17
        exec && set_ok && sel == hpsr_pkg::SEL_EN
            && st_w[port_ix][hpsr_pkg::ST_PWR] && st_w[port_ix][hpsr_pkg::ST_CONN]
            && !ovc_lvl[port_ix] |=> st_w[$past(port_ix)][hpsr_pkg::ST_EN])
        else $error("accepted enable set ignored");

    a_clr_power_off: assert property (@(posedge pclk) disable iff (!presetn) // RULE_20
        exec && clr_ok && sel == hpsr_pkg::SEL_PWR
            |=> !port_pwr[$past(port_ix)])
        else $error("power clear ignored");

    a_change_clear: assert property (@(posedge pclk) disable iff (!presetn) // RULE_21
        exec && clr_ok && sel == hpsr_pkg::SEL_C_BASE && port_ix == 2'd0
            && !$changed(conn_lvl[0]) |=> !ch_w[0][0])
        else $error("connect change not cleared");

    a_accept_no_stall: assert property (@(posedge pclk) disable iff (!presetn) // RULE_14
        exec && set_ok |=> done_q && ack_q && !stall_q)
        else $error("accepted port set stalled");

    a_reset_done_flag: assert property (@(posedge pclk) disable iff (!presetn) // RULE_10
        $fell(port_rst_drv[0]) && conn_lvl[0] |-> ch_w[0][4])
        else $error("reset completion not flagged");

    a_clr_oc_done: assert property (@(posedge pclk) disable iff (!presetn) // RULE_20
        exec && clr_ok && sel == hpsr_pkg::SEL_OC && !ovc_lvl[port_ix]
            |=> !st_w[$past(port_ix)][hpsr_pkg::ST_OC])
        else $error("over-current clear ignored");

    a_get_len_stall: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
        exec && is_get && rq_len != hpsr_pkg::LEN_STATUS |=> stall_q && !ack_q)
        else $error("bad status length accepted");

    c_get_status: cover property (@(posedge pclk) disable iff (!presetn)
        exec && get_ok);
    c_set_reset: cover property (@(posedge pclk) disable iff (!presetn)
        exec && set_ok && sel == hpsr_pkg::SEL_RST);
    c_clr_change: cover property (@(posedge pclk) disable iff (!presetn)
        exec && clr_ok && sel_chg);
    c_over_current: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(st_w[0][hpsr_pkg::ST_OC]));
    c_clr_power: cover property (@(posedge pclk) disable iff (!presetn)
        exec && clr_ok && sel == hpsr_pkg::SEL_PWR);

endmodule : hpsr_top

// ==== tb_hub_port_status_requests.sv ====
`timescale 1ns/1ps
module tb_hub_port_status_requests;
    localparam int RC = 40;
    localparam logic [31:0] ACK = 32'h0000_0003;
    localparam logic [31:0] STL = 32'h0000_0005;
    localparam logic [31:0] ALL = 32'hffff_ffff;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, r;
    logic [3:0] conn_pin, lspd_pin, ovc_pin, port_pwr, port_rst_drv, attach, low_spd, fault;
    logic [23:0] bad [8] = '{24'h03_0001, 24'h03_0301, 24'h03_0901, 24'h01_0001,
                             24'h01_0401, 24'h01_0901, 24'h03_0800, 24'h03_0805};
    int n_fail = 0;
    int tests_run = 0;
    int seed = 35;

    hpsr_top #(.NPORT(4), .RST_CYC(RC)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conn_pin(conn_pin), .lspd_pin(lspd_pin),
        .ovc_pin(ovc_pin), .port_pwr(port_pwr), .port_rst_drv(port_rst_drv));
    hpsr_dev_model far (.attach(attach), .low_spd(low_spd), .fault(fault),
        .conn_pin(conn_pin), .lspd_pin(lspd_pin), .ovc_pin(ovc_pin));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic test_done;
        $display("checks %0d errors %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // {chg[4:0], ls, pwr, rst, oc, susp, en, conn} laid out as status and change words
    function automatic logic [31:0] word(input logic [4:0] c, input logic [6:0] s);
        return {11'h000, c, 6'h00, s[6:5], 3'h0, s[4:0]};
    endfunction : word

    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask : wt

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic req(input logic [7:0] t, input logic [7:0] q, input logic [15:0] v,
                       input logic [15:0] i, input logic [15:0] l, input logic [31:0] e);
        apb(1'b1, hpsr_pkg::ADDR_SETUP_LO, {v, q, t});
        apb(1'b1, hpsr_pkg::ADDR_SETUP_HI, {l, i});
        do begin
            apb(1'b0, hpsr_pkg::ADDR_RESULT, 32'h0000_0000);
        end while (rd[0] !== 1'b1);
        chk(rd, e, "request result");
    endtask : req

    // port feature request; the don't-care top bit of the type is drawn at random
    task automatic sf(input logic [7:0] q, input logic [7:0] s, input logic [15:0] i,
                      input logic [31:0] e);
        r = $random(seed);
        req({r[0], hpsr_pkg::RT_PORT_SET}, q, {8'h00, s}, i, hpsr_pkg::LEN_NONE, e);
    endtask : sf

    task automatic gs(input logic [15:0] i, input logic [31:0] m, input logic [31:0] e);
        req(hpsr_pkg::RT_PORT_GET, hpsr_pkg::RQ_GET_STATUS, hpsr_pkg::VAL_NONE, i,
            hpsr_pkg::LEN_STATUS, ACK);
        apb(1'b0, hpsr_pkg::ADDR_REPLY, 32'h0000_0000);
        chk(rd & m, e, "port reply");
    endtask : gs

    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        test_done();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {attach, low_spd, fault} = '0;
        presetn = 1'b0;
        wt(6);
        presetn <= 1'b1;
        gs(1, ALL, word(5'h00, 7'h00));
        wt(1);
        attach[0] <= 1'b1;
        low_spd[0] <= 1'b1;
        wt(10);
        gs(1, ALL, word(5'h01, 7'h41));
        sf(8'h03, 8'h08, 1, ACK);
        chk({31'h0, port_pwr[0]}, 32'h0000_0001, "power pin");
        sf(8'h01, 8'h10, 1, ACK);
        gs(1, ALL, word(5'h00, 7'h61));
        sf(8'h03, 8'h04, 1, ACK);
        chk({31'h0, port_rst_drv[0]}, 32'h0000_0001, "reset pin");
        gs(1, ALL, word(5'h00, 7'h71));
        wt(RC + 10);
        chk({31'h0, port_rst_drv[0]}, 32'h0000_0000, "reset pin");
        gs(1, ALL, word(5'h12, 7'h63));
        sf(8'h01, 8'h11, 1, ACK);
        sf(8'h01, 8'h14, 1, ACK);
        sf(8'h03, 8'h02, 1, ACK);
        gs(1, ALL, word(5'h00, 7'h67));
        sf(8'h01, 8'h02, 1, ACK);
        gs(1, ALL, word(5'h04, 7'h63));
        sf(8'h01, 8'h12, 1, ACK);
        sf(8'h01, 8'h01, 1, ACK);
        gs(1, ALL, word(5'h02, 7'h61));
        sf(8'h01, 8'h11, 1, ACK);
        foreach (bad[k]) sf(bad[k][23:16], bad[k][15:8], {8'h00, bad[k][7:0]}, STL);
        r = $random(seed);
        req(8'h20, hpsr_pkg::RQ_SET_DESC, r[15:0], r[31:16], r[15:0], STL);
        req({r[3], 7'h20}, hpsr_pkg::RQ_SET_FEATURE, r[31:16], r[15:0], r[31:16], STL);
        req(8'ha3, 8'h0b, 16'h0000, 16'h0000, 16'h0004, STL);
        req(8'ha3, 8'h0b, 16'h0000, 16'h0001, 16'h0002, STL);
        gs(1, ALL, word(5'h00, 7'h61));
        for (int p = 2; p <= 4; p++) begin
            r = $random(seed);
            attach[p-1] <= r[0];
            low_spd[p-1] <= r[1];
            wt(10);
            gs(p[15:0], ALL, word({4'h0, r[0]}, {r[0] & r[1], 5'h00, r[0]}));
        end
        fault[0] <= 1'b1;
        wt(10);
        chk({31'h0, port_pwr[0]}, 32'h0000_0000, "power pin");
        gs(1, 32'h0008_0108, 32'h0008_0008);
        fault[0] <= 1'b0;
        wt(10);
        sf(8'h01, 8'h03, 1, ACK);
        sf(8'h03, 8'h08, 1, ACK);
        sf(8'h03, 8'h01, 1, ACK);
        gs(1, ALL, word(5'h0a, 7'h63));
        sf(8'h01, 8'h08, 1, ACK);
        gs(1, ALL, word(5'h0a, 7'h41));
        apb(1'b0, 8'h3c, 32'h0000_0000);
        chk({31'h0, er}, 32'h0000_0001, "unmapped error");
        apb(1'b1, hpsr_pkg::ADDR_RESULT, 32'h0000_0007);
        chk({31'h0, er}, 32'h0000_0001, "read-only error");
        test_done();
    end
endmodule : tb_hub_port_status_requests
